// File: hdl/axs_regs.svh
`ifndef AXS_REGS_SVH
`define AXS_REGS_SVH
`define AXS_OFF_CTRL      8'h00
`define AXS_OFF_STATUS    8'h04
`define AXS_OFF_SCANEN    8'h08
`define AXS_OFF_IRQ_STAT  8'h0c
`define AXS_OFF_IRQ_MASK  8'h10
`define AXS_OFF_SAMPLE    8'h14
`define AXS_OFF_RES_BAT   8'h20
`define AXS_OFF_RES_AUX_INPUT_ONE  8'h24
`define AXS_OFF_RES_AUX_INPUT_TWO  8'h28
`define AXS_OFF_RES_TMP1  8'h2c
`define AXS_OFF_RES_TMP2  8'h30
`define AXS_CTRL_STOP     14
`define AXS_CTRL_SCAN_LO  10
`define AXS_CTRL_RES_LO   8
`define AXS_CTRL_AVG_LO   6
`define AXS_CTRL_RATE_LO  4
`define AXS_CTRL_FILT     0
`define AXS_STAT_PIN_LO   14
`define AXS_STAT_OFF      13
`define AXS_STAT_PEND     11
`define AXS_PINFN_RESET   2'b10
`define AXS_CLK_MHZ       50
`define AXS_TICK_NS_R0    500
`define AXS_TICK_NS_R1    250
`define AXS_TICK_NS_R2    125
`define AXS_TICK_NS_R3    100
`define AXS_TICK_CYC(ns)  ((((ns) * `AXS_CLK_MHZ) + 999) / 1000)
`define AXS_EXTRA_TICKS   4
`endif

// File: hdl/axs_pkg.sv
package axs_pkg;
	typedef enum logic [3:0] {
		AXS_SCAN_NONE = 4'h0,
		AXS_SCAN_BAT  = 4'h6,
		AXS_SCAN_AUX_INPUT_TWO = 4'h7,
		AXS_SCAN_AUX_INPUT_ONE = 4'h8,
		AXS_SCAN_AUTO = 4'h9,
		AXS_SCAN_TMP1 = 4'ha,
		AXS_SCAN_PORT = 4'hb,
		AXS_SCAN_TMP2 = 4'hc
	} axs_scan_e;
	typedef enum logic [3:0] {
		AXS_ST_IDLE = 4'b0001,
		AXS_ST_PICK = 4'b0010,
		AXS_ST_CONV = 4'b0100,
		AXS_ST_DONE = 4'b1000
	} axs_state_e;
	typedef logic [2:0] axs_chan_t;
endpackage

// File: hdl/axs_sampler.sv
`timescale 1ns/1ps
`include "axs_regs.svh"
// one conversion: tick generator plus averaging of samples
module axs_sampler (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// control
	input  wire logic        start,
	input  wire logic [1:0]  res_sel,
	input  wire logic [1:0]  avg_sel,
	input  wire logic [1:0]  rate_sel,
	input  wire logic        median,
	input  wire logic [11:0] sample_in,
	// result
	output logic             done,
	output logic [11:0]      result
);
	localparam logic [7:0] TICK0 = 8'(`AXS_TICK_CYC(`AXS_TICK_NS_R0));
	localparam logic [7:0] TICK1 = 8'(`AXS_TICK_CYC(`AXS_TICK_NS_R1));
	localparam logic [7:0] TICK2 = 8'(`AXS_TICK_CYC(`AXS_TICK_NS_R2));
	localparam logic [7:0] TICK3 = 8'(`AXS_TICK_CYC(`AXS_TICK_NS_R3));
	logic        busy_q;
	logic [7:0]  div_q;
	logic [4:0]  bit_q;
	logic [4:0]  cnt_q;
	logic [15:0] sum_q;
	logic [11:0] min_q;
	logic [11:0] max_q;
	wire  [7:0]  tick_len = (rate_sel == 2'd0) ? TICK0 : (rate_sel == 2'd1) ? TICK1 :
		(rate_sel == 2'd2) ? TICK2 : TICK3;
	wire  [4:0]  nbits = (res_sel == 2'b01) ? 5'd8 : (res_sel == 2'b10) ? 5'd10 : 5'd12;
	wire  [4:0]  ticks = nbits + 5'(`AXS_EXTRA_TICKS);
	wire  [4:0]  nsamp = !median ? ((avg_sel == 2'd0) ? 5'd1 : (avg_sel == 2'd1) ? 5'd4 :
		(avg_sel == 2'd2) ? 5'd8 : 5'd16) : ((avg_sel == 2'd0) ? 5'd1 :
		(avg_sel == 2'd1) ? 5'd5 : (avg_sel == 2'd2) ? 5'd9 : 5'd15);
	wire  [11:0] mask = (res_sel == 2'b01) ? 12'hff0 : (res_sel == 2'b10) ? 12'hffc : 12'hfff;
	wire  [11:0] smp = sample_in & mask;
	wire         tick_end = (div_q == tick_len - 8'd1);
	wire         conv_end = busy_q && tick_end && (bit_q == ticks - 5'd1);
	wire         last = conv_end && (cnt_q == nsamp - 5'd1);
	wire  [15:0] sum_n = sum_q + {4'h0, smp};
	wire  [11:0] min_n = (smp < min_q) ? smp : min_q;
	wire  [11:0] max_n = (smp > max_q) ? smp : max_q;
	// median approximated as midrange: true sort would cost a 15-entry network
	wire  [12:0] mid = {1'b0, min_n} + {1'b0, max_n};
	wire  [15:0] mean = (avg_sel == 2'd0) ? sum_n : (avg_sel == 2'd1) ? (sum_n >> 2) :
		(avg_sel == 2'd2) ? (sum_n >> 3) : (sum_n >> 4);
	always_ff @(posedge clock) begin
		if (srst) begin
			busy_q <= 1'b0;
			div_q  <= 8'h00;
			bit_q  <= 5'h00;
			cnt_q  <= 5'h00;
			sum_q  <= 16'h0000;
			min_q  <= 12'hfff;
			max_q  <= 12'h000;
			done   <= 1'b0;
			result <= 12'h000;
		end else begin
			done <= last;
			if (start && !busy_q) begin
				busy_q <= 1'b1;
				div_q  <= 8'h00;
				bit_q  <= 5'h00;
				cnt_q  <= 5'h00;
				sum_q  <= 16'h0000;
				min_q  <= 12'hfff;
				max_q  <= 12'h000;
			end else if (busy_q) begin
				div_q <= tick_end ? 8'h00 : div_q + 8'd1;
				if (tick_end)
					bit_q <= conv_end ? 5'h00 : bit_q + 5'd1;
				if (conv_end) begin
					cnt_q <= cnt_q + 5'd1;
					sum_q <= sum_n;
					min_q <= min_n;
					max_q <= max_n;
				end
				if (last) begin
					busy_q <= 1'b0;
					result <= (median && avg_sel != 2'd0) ? mid[12:1] : mean[11:0];
				end
			end
		end
	end
endmodule // axs_sampler

// File: hdl/axs_scan_ctrl.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "axs_regs.svh"
module axs_scan_ctrl (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// converter front end
	output logic [2:0]       mux_select,
	input  wire logic [11:0] sample_in,
	// pins
	output logic             result_ready_pin_n,
	output logic             irq
);
	logic [1:0]  pin_fn_q;
	logic [3:0]  scan_q;
	logic [1:0]  res_q;
	logic [1:0]  avg_q;
	logic [1:0]  rate_q;
	logic        filt_q;
	logic [3:0]  scan_en_q;
	logic [4:0]  fresh_q;
	logic        off_q;
	logic        pending_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [11:0] res_bank_q [0:4];
	logic [4:0]  need_q;
	logic [2:0]  chan_q;
	axs_pkg::axs_state_e state_q;
	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        samp_start;
	logic        samp_done;
	logic [11:0] samp_res;

	// channel indexes: 0 bat, 1 aux_input_one, 2 aux_input_two, 3 temp_sense_one, 4 temp_sense_two
	function automatic logic [4:0] scan_set(input logic [3:0] code, input logic [3:0] en);
		unique case (code)
			axs_pkg::AXS_SCAN_BAT:  scan_set = 5'b00001;
			axs_pkg::AXS_SCAN_AUX_INPUT_ONE: scan_set = 5'b00010;
			axs_pkg::AXS_SCAN_AUX_INPUT_TWO: scan_set = 5'b00100;
			axs_pkg::AXS_SCAN_TMP1: scan_set = 5'b01000;
			axs_pkg::AXS_SCAN_TMP2: scan_set = 5'b10000;
			axs_pkg::AXS_SCAN_AUTO: scan_set = {en, 1'b0};
			axs_pkg::AXS_SCAN_PORT: scan_set = 5'b00111;
			default:                scan_set = 5'b00000;
		endcase
	endfunction
	function automatic logic [2:0] first_chan(input logic [4:0] set);
		first_chan = set[0] ? 3'd0 : set[1] ? 3'd1 : set[2] ? 3'd2 : set[3] ? 3'd3 : 3'd4;
	endfunction
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	wire        aw_take = s_axi_awvalid && s_axi_awready;
	wire        w_take  = s_axi_wvalid && s_axi_wready;
	wire        wr_go   = (aw_q || aw_take) && (w_q || w_take);
	wire [7:0]  wa      = aw_take ? s_axi_awaddr : awaddr_q;
	wire [31:0] wd      = w_take ? s_axi_wdata : wdata_q;
	wire [3:0]  ws      = w_take ? s_axi_wstrb : wstrb_q;
	wire        wr_ctrl = wr_go && (wa == `AXS_OFF_CTRL);
	wire        wr_stat = wr_go && (wa == `AXS_OFF_STATUS);
	wire        wr_en   = wr_go && (wa == `AXS_OFF_SCANEN);
	wire        wr_ist  = wr_go && (wa == `AXS_OFF_IRQ_STAT);
	wire        wr_imk  = wr_go && (wa == `AXS_OFF_IRQ_MASK);
	wire        wr_ok   = wr_ctrl || wr_stat || wr_en || wr_ist || wr_imk;
	wire [15:0] ctrl_rd = {1'b0, state_q == axs_pkg::AXS_ST_IDLE, scan_q, res_q, avg_q,
		rate_q, 3'b000, filt_q};
	wire [15:0] ctrl_nw = lane_merge(ctrl_rd, wd, ws);
	// stop comes from the written lane only, never from the idle bit that reads back there
	wire        stop_wr = wr_ctrl && ws[1] && wd[`AXS_CTRL_STOP];
	wire [3:0]  scan_nw = ctrl_nw[`AXS_CTRL_SCAN_LO +: 4];
	wire        scan_wr = wr_ctrl && !stop_wr && ws[1];
	wire [4:0]  nw_set  = scan_set(scan_nw, scan_en_q);
	wire        start_wr = scan_wr && (nw_set != 5'b00000);

	// read channel: one cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	wire        ar_take = s_axi_arvalid && s_axi_arready;
	wire [7:0]  ra      = s_axi_araddr;
	wire        rd_hit_res = ar_take && (ra >= `AXS_OFF_RES_BAT) && (ra <= `AXS_OFF_RES_TMP2)
		&& (ra[1:0] == 2'b00);
	wire [2:0]  rd_idx  = 3'((ra - `AXS_OFF_RES_BAT) >> 2);
	wire [4:0]  rd_clr  = rd_hit_res ? (5'b00001 << rd_idx) : 5'b00000;
	wire [15:0] stat_rd = {pin_fn_q, off_q, 1'b0, pending_q, 4'h0, fresh_q[0], 1'b0,
		fresh_q[1], fresh_q[2], fresh_q[3], fresh_q[4], 1'b0};
	wire        rd_ok   = (ra == `AXS_OFF_CTRL) || (ra == `AXS_OFF_STATUS) ||
		(ra == `AXS_OFF_SCANEN) || (ra == `AXS_OFF_IRQ_STAT) || (ra == `AXS_OFF_IRQ_MASK) ||
		rd_hit_res;
	wire [15:0] rd_val  = (ra == `AXS_OFF_CTRL) ? ctrl_rd : (ra == `AXS_OFF_STATUS) ? stat_rd :
		(ra == `AXS_OFF_SCANEN) ? {12'h000, scan_en_q} :
		(ra == `AXS_OFF_IRQ_STAT) ? {14'h0000, irq_stat_q} :
		(ra == `AXS_OFF_IRQ_MASK) ? {14'h0000, irq_mask_q} :
		rd_hit_res ? {4'h0, res_bank_q[rd_idx]} : 16'h0000;

	always_ff @(posedge clock) begin
		if (srst) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'b00;
			s_axi_rdata  <= 32'h0000_0000;
		end else begin
			if (aw_take) awaddr_q <= s_axi_awaddr;
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_q <= wr_go ? 1'b0 : (aw_q || aw_take);
			w_q  <= wr_go ? 1'b0 : (w_q || w_take);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
				s_axi_rdata  <= {16'h0000, rd_val};
			end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clock) begin
		if (srst) begin
			scan_q     <= 4'h0;
			res_q      <= 2'b00;
			avg_q      <= 2'b00;
			rate_q     <= 2'b00;
			filt_q     <= 1'b0;
			pin_fn_q   <= `AXS_PINFN_RESET;
			scan_en_q  <= 4'h0;
			irq_mask_q <= 2'b00;
		end else begin
			if (wr_ctrl) begin
				res_q  <= ctrl_nw[`AXS_CTRL_RES_LO +: 2];
				avg_q  <= ctrl_nw[`AXS_CTRL_AVG_LO +: 2];
				rate_q <= ctrl_nw[`AXS_CTRL_RATE_LO +: 2];
				filt_q <= ctrl_nw[`AXS_CTRL_FILT];
			end
			if (stop_wr) scan_q <= 4'h0;
			else if (scan_wr) scan_q <= scan_nw;
			if (wr_stat && ws[1]) pin_fn_q <= wd[`AXS_STAT_PIN_LO +: 2];
			if (wr_en && ws[0]) scan_en_q <= wd[3:0];
			if (wr_imk && ws[0]) irq_mask_q <= wd[1:0];
		end
	end

	// sequencer
	wire [4:0]  seq_set = scan_set(scan_q, scan_en_q);
	wire [4:0]  left    = need_q & ~(5'b00001 << chan_q);
	wire        set_end = samp_done && (left == 5'b00000);
	wire        abort   = stop_wr || scan_wr;
	assign samp_start = (state_q == axs_pkg::AXS_ST_PICK);
	assign mux_select = chan_q;
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= axs_pkg::AXS_ST_IDLE;
			need_q  <= 5'b00000;
			chan_q  <= 3'd0;
			off_q   <= 1'b0;
			for (int i = 0; i < 5; i++) res_bank_q[i] <= 12'h000;
		end else begin
			unique case (state_q)
				axs_pkg::AXS_ST_IDLE: begin
					if (start_wr) begin
						need_q  <= nw_set;
						chan_q  <= first_chan(nw_set);
						state_q <= axs_pkg::AXS_ST_PICK;
						off_q   <= 1'b0;
					end
				end
				axs_pkg::AXS_ST_PICK: state_q <= axs_pkg::AXS_ST_CONV;
				axs_pkg::AXS_ST_CONV: begin
					if (samp_done) res_bank_q[chan_q] <= samp_res;
					if (set_end) state_q <= axs_pkg::AXS_ST_DONE;
					else if (samp_done) begin
						need_q  <= left;
						chan_q  <= first_chan(left);
						state_q <= axs_pkg::AXS_ST_PICK;
					end
				end
				axs_pkg::AXS_ST_DONE: begin
					if (scan_q == axs_pkg::AXS_SCAN_AUTO && seq_set != 5'b00000 && !abort) begin
						need_q  <= seq_set;
						chan_q  <= first_chan(seq_set);
						state_q <= axs_pkg::AXS_ST_PICK;
					end else state_q <= axs_pkg::AXS_ST_IDLE;
				end
				default: state_q <= axs_pkg::AXS_ST_IDLE;
			endcase
			// a stop or scan change wins over the running sequence
			if (abort && state_q != axs_pkg::AXS_ST_IDLE)
				state_q <= axs_pkg::AXS_ST_IDLE;
			if (stop_wr) off_q <= 1'b1;
		end
	end

	// result tracking: a new result beats a same-cycle read
	wire [4:0] done_bit = (samp_done && state_q == axs_pkg::AXS_ST_CONV) ?
		(5'b00001 << chan_q) : 5'b00000;
	wire       set_ev   = set_end && state_q == axs_pkg::AXS_ST_CONV;
	wire [4:0] fresh_n  = (fresh_q & ~rd_clr) | done_bit;
	wire       stop_ev  = stop_wr && !off_q;
	always_ff @(posedge clock) begin
		if (srst) begin
			fresh_q    <= 5'b00000;
			pending_q  <= 1'b0;
			irq_stat_q <= 2'b00;
		end else begin
			fresh_q <= fresh_n;
			if (set_ev) pending_q <= 1'b1;
			else if (fresh_n == 5'b00000) pending_q <= 1'b0;
			irq_stat_q <= ((wr_ist && ws[0]) ? (irq_stat_q & ~wd[1:0]) : irq_stat_q)
				| {stop_ev, set_ev};
		end
	end
	assign result_ready_pin_n = !(pending_q && pin_fn_q == 2'b01);
	assign irq = |(irq_stat_q & irq_mask_q);

	axs_sampler u_sampler (
		.clock     (clock),
		.srst      (srst),
		.start     (samp_start),
		.res_sel   (res_q),
		.avg_sel   (avg_q),
		.rate_sel  (rate_q),
		.median    (filt_q),
		.sample_in (sample_in),
		.done      (samp_done),
		.result    (samp_res)
	);
endmodule // axs_scan_ctrl

// File: bench/axs_scan_ctrl_asserts.sv
`timescale 1ns/1ps
module axs_scan_ctrl_asserts (
	// clock and reset
	input wire logic        clock,
	input wire logic        srst,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins
	input wire logic [2:0]  mux_select,
	input wire logic        result_ready_pin_n,
	input wire logic        irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// address of the read now being answered
	logic [7:0] ar_q;
	always_ff @(posedge clock) begin
		if (srst)
			ar_q <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	a_reset_idle: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid
		&& result_ready_pin_n && !irq && mux_select == 3'h0)
		else $error("outputs not idle after reset");
	a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready not the inverse of rvalid");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
	a_mux_range: assert property (mux_select <= 3'h4)
		else $error("channel select out of range");
	a_result_upper: assert property (
		s_axi_rvalid && ar_q >= 8'h20 && ar_q <= 8'h30 |-> s_axi_rdata[31:12] == 20'h00000)
		else $error("result upper bits not zero");
	a_unmapped_err: assert property (s_axi_rvalid && ar_q > 8'h30 |-> s_axi_rresp == 2'b10
		&& s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	a_pin_fn_off: assert property (
		s_axi_rvalid && ar_q == 8'h04 && s_axi_rdata[15:14] != 2'b01 |-> result_ready_pin_n)
		else $error("ready pin low with pin function not selected");
endmodule // axs_scan_ctrl_asserts

// File: bench/axs_front_model.sv
`timescale 1ns/1ps
module axs_front_model (
	// channel under conversion
	input wire logic [2:0]  mux_select,
	// level set by the bench
	input wire logic [11:0] base_level,
	// sample to the converter
	output logic [11:0]     sample_in
);
	// each channel sits its own step above the base, so a wrong mux shows up
	assign sample_in = base_level + {1'b0, mux_select, 8'h00};
endmodule // axs_front_model

// File: bench/aux_adc_scan_control_tb.sv
`timescale 1ns/1ps
`include "axs_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module aux_adc_scan_control_tb;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [11:0] base_level = 12'h000;
	logic        awready, wready, bvalid, arready, rvalid, pin_n, irq;
	logic [31:0] rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  mux_select;
	logic [11:0] sample_in;
	int          err_total = 0;
	int          n_tests = 0;
	int          i;
	axs_scan_ctrl dut (.clock(clock), .srst(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mux_select(mux_select), .sample_in(sample_in),
		.result_ready_pin_n(pin_n), .irq(irq));
	axs_front_model fe (.mux_select(mux_select), .base_level(base_level),
		.sample_in(sample_in));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		$display("Error at %0t: got %h exp %h", $time, 1'b0, 1'b1);
		results();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int  k;
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100 && !(aw_ok && w_ok); k++) begin
			@(posedge clock);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		for (k = 0; k < 100; k++) begin
			@(posedge clock);
			if (bvalid)
				break;
		end
		if (k == 100)
			hang();
		`CHK(bresp, 2'b00)
		bready <= 1'b0;
		// let the release land before the next request
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (k == 100)
			hang();
		v = rdata;
		e = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	// one set of conversions, then every result read back against the model
	task automatic run_set(input logic [3:0] code, input int chans[$], input bit rep);
		logic [1:0] res, avg, rate;
		logic       filt;
		int         msk;
		res = 2'($urandom);
		// fast rates only with reduced resolution
		rate = (res == 2'b01) ? 2'b11 : (res == 2'b10) ? 2'b10 : 2'b00;
		avg = (rate != 2'b00) ? 2'($urandom) : 2'($urandom % 2);
		filt = 1'($urandom);
		msk = (res == 2'b01) ? 'hff0 : (res == 2'b10) ? 'hffc : 'hfff;
		base_level <= 12'($urandom);
		wr(`AXS_OFF_CTRL, {18'h0, code, res, avg, rate, 3'b000, filt});
		rd(`AXS_OFF_CTRL, d, r);
		`CHK(d[5:4], rate)
		for (i = 0; i < 40000; i++) begin
			@(posedge clock);
			if (!pin_n)
				break;
		end
		if (i == 40000)
			hang();
		`CHK(irq, 1'b1)
		rd(`AXS_OFF_STATUS, d, r);
		`CHK(d[11], 1'b1)
		`CHK(d[13], 1'b0)
		foreach (chans[k]) begin
			rd(8'(32 + chans[k] * 4), d, r);
			`CHK(d, 32'(((base_level + chans[k] * 256) % 4096) & msk))
		end
		if (!rep) begin
			rd(`AXS_OFF_STATUS, d, r);
			`CHK(d[11], 1'b0)
			`CHK(pin_n, 1'b1)
			wr(`AXS_OFF_IRQ_STAT, 32'h1);
			`CHK(irq, 1'b0)
		end
		$display("set %h done", code);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		void'($urandom(84923));
		@(posedge clock);
		rd(`AXS_OFF_STATUS, d, r);
		`CHK(d[15:14], `AXS_PINFN_RESET)
		`CHK(d[11], 1'b0)
		rd(`AXS_OFF_CTRL, d, r);
		`CHK(d[14], 1'b1)
		rd(8'h3c, d, r);
		`CHK(r, 2'b10)
		wr(`AXS_OFF_STATUS, 32'h4000);
		wr(`AXS_OFF_IRQ_MASK, 32'h1);
		$display("register checks done");
		wr(`AXS_OFF_CTRL, 32'h0);
		for (i = 0; i < 2000 && pin_n; i++) @(posedge clock);
		`CHK(pin_n, 1'b1)
		rd(`AXS_OFF_CTRL, d, r);
		`CHK(d[14], 1'b1)
		$display("no scan done");
		run_set(4'h6, '{0}, 1'b0);
		run_set(4'h7, '{2}, 1'b0);
		run_set(4'h8, '{1}, 1'b0);
		run_set(4'ha, '{3}, 1'b0);
		run_set(4'hc, '{4}, 1'b0);
		run_set(4'hb, '{0, 1, 2}, 1'b0);
		wr(`AXS_OFF_SCANEN, 32'hf);
		run_set(4'h9, '{1, 2, 3, 4}, 1'b1);
		// auto scan must still be running after its first set was read out
		rd(`AXS_OFF_CTRL, d, r);
		`CHK(d[14], 1'b0)
		wr(`AXS_OFF_CTRL, 32'h4000);
		for (i = 0; i < 50; i++) begin
			rd(`AXS_OFF_STATUS, d, r);
			if (d[13])
				break;
		end
		`CHK(d[13], 1'b1)
		rd(`AXS_OFF_CTRL, d, r);
		`CHK(d[14], 1'b1)
		$display("stop done");
		results();
	end
endmodule // aux_adc_scan_control_tb
bind axs_scan_ctrl axs_scan_ctrl_asserts chk (.clock(clock), .srst(srst),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mux_select(mux_select),
	.result_ready_pin_n(result_ready_pin_n), .irq(irq));
